// ### rtl/ias_sequencer.sv
// How it works
// - Start servicing a pending request only at a boundary and after higher exceptions.
// - Stack program counter and status word before the acknowledge cycle.
// - Drive function code lines to all ones during the acknowledge cycle.
// - Acknowledge address bits 23 to 4 all ones and bit 0 one.
// - Acknowledge address bits 3 to 1 carry the acknowledged level.
// - Acknowledged level from the address is loaded into the priority mask.
// - No contender means bus error, handled as a spurious interrupt.
// - Vector with size acknowledge ends the cycle; the vector is captured.
// - Autovector request yields an autovector number for the acknowledged level.
// - Bus error ending the cycle selects the spurious vector number.
// - Vector becomes a table address; its word loads the program counter.
// - Status word holds trace, supervisor, zero bits and priority mask.
// - Low byte holds zero bits then extend, negative, zero, overflow, carry.
// - User level sees only the condition byte; supervisor sees everything.
// - Supervisor bit selects privilege; whole-word status read is privileged.
// - Sixteen general registers, PC, SSP, status word, SFC, DFC and VBR.
// - Requests at or below the mask are ignored, except level seven.
`timescale 1ns/1ps
module ias_sequencer (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:1]  irq_n_i,
  input  wire logic        boundary_i,
  input  wire logic        exc_busy_i,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [31:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  output logic             ack_cycle_o,
  output logic [2:0]       function_code_lines_o,
  output logic [23:0]      ack_addr_o,
  input  wire logic [7:0]  ack_vector_i,
  input  wire logic [1:0]  size_ack_lines_n_i,
  input  wire logic        autovector_req_n_i,
  input  wire logic        bus_error_in_n_i,
  output logic             resume_o,
  output logic [31:0]      pc_o,
  output logic             spurious_o,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  input  wire logic [4:0]  reg_sel_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic [31:0]      reg_rdata_o,
  input  wire logic        sw_wr_i,
  input  wire logic        sw_wr_full_i,
  input  wire logic [15:0] sw_wdata_i,
  input  wire logic        sw_rd_i,
  input  wire logic        sw_rd_full_i,
  output logic [15:0]      sw_rdata_o,
  output logic             priv_fault_o
);
  import ias_pkg::*;

  ias_sw_if    swif ();
  ias_state_e  state_q;
  ias_state_e  state_d;

  logic [7:1]  irq_s1_q;
  logic [7:1]  irq_s2_q;
  logic [7:1]  irq_s3_q;
  logic [7:1]  irq_valid;
  logic [11:0] term_s1_q;
  logic [11:0] term_s2_q;
  logic        bus_error_in_seen;
  logic        autovector_req_seen;
  logic        size_ack_lines_seen;
  logic [7:0]  vec_sync;
  logic        irq7_prev_q;
  logic [2:0]  mask_prev_q;
  logic        nmi_pend_q;
  logic        nmi_set;
  logic        nmi_clr;
  logic [2:0]  best_lvl;
  logic [2:0]  lvl_q;
  logic        mask_load_q;
  logic [7:0]  vec_num;
  logic [31:0] gpr_q [16];
  logic [31:0] pc_q;
  logic [31:0] ssp_q;
  logic [31:0] vbr_q;
  logic [2:0]  sfc_q;
  logic [2:0]  dfc_q;
  logic        reg_fault_q;
  logic        priv_sel;
  logic        take;

  ias_status_word u_status_word (
    .clock_i      (clock_i),
    .reset_n_i    (reset_n_i),
    .sw           (swif.owner),
    .sw_wr_i      (sw_wr_i),
    .sw_wr_full_i (sw_wr_full_i),
    .sw_wdata_i   (sw_wdata_i),
    .sw_rd_i      (sw_rd_i),
    .sw_rd_full_i (sw_rd_full_i),
    .sw_rdata_o   (sw_rdata_o)
  );

  // Request pins are synchronised, then must hold two samples to count.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_s1_q <= 7'h00;
      irq_s2_q <= 7'h00;
      irq_s3_q <= 7'h00;
    end else begin
      irq_s1_q <= ~irq_n_i;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
    end
  end
  assign irq_valid = irq_s2_q & irq_s3_q;

  // Terminations and the vector come from pins and are synchronised too.
  // The vector must therefore stay valid as long as its termination does.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      term_s1_q <= 12'h000;
      term_s2_q <= 12'h000;
    end else begin
      term_s1_q <= {~bus_error_in_n_i, ~autovector_req_n_i,
                    ~size_ack_lines_n_i, ack_vector_i};
      term_s2_q <= term_s1_q;
    end
  end
  assign bus_error_in_seen  = term_s2_q[11];
  assign autovector_req_seen  = term_s2_q[10];
  assign size_ack_lines_seen = |term_s2_q[9:8];
  assign vec_sync   = term_s2_q[7:0];

  // Level seven is taken once per assertion and again when the mask drops from seven.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq7_prev_q <= 1'b0;
      mask_prev_q <= LVL_NMI;
    end else begin
      irq7_prev_q <= irq_valid[7];
      mask_prev_q <= swif.word[SW_IP_HI:SW_IP_LO];
    end
  end
  assign nmi_set = irq_valid[7] &
                   (~irq7_prev_q |
                    ((mask_prev_q == LVL_NMI) &&
                     (swif.word[SW_IP_HI:SW_IP_LO] != LVL_NMI)));
  assign nmi_clr = (state_q == ST_PUSH_SW) && mem_ack_i && (lvl_q == LVL_NMI);

  // A new edge in the clearing cycle keeps the request pending.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_set) begin
      nmi_pend_q <= 1'b1;
    end else if (nmi_clr) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // Maskable levels are not latched: the highest live one above the mask.
  always_comb begin
    best_lvl = LVL_NONE;
    for (int i = 1; i < 7; i++) begin
      if (irq_valid[i] && (3'(i) > swif.word[SW_IP_HI:SW_IP_LO])) begin
        best_lvl = 3'(i);
      end
    end
    if (nmi_pend_q) begin
      best_lvl = LVL_NMI;
    end
  end

  assign take = (best_lvl != LVL_NONE) && boundary_i && !exc_busy_i;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (best_lvl != LVL_NONE) begin
          state_d = ST_WAIT_BND;
        end
      end
      ST_WAIT_BND: begin
        if (best_lvl == LVL_NONE) begin
          state_d = ST_IDLE;
        end else if (take) begin
          state_d = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        if (mem_ack_i) begin
          state_d = ST_PUSH_SW;
        end
      end
      ST_PUSH_SW: begin
        if (mem_ack_i) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        if (bus_error_in_seen || autovector_req_seen || size_ack_lines_seen) begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (mem_ack_i) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lvl_q <= LVL_NONE;
    end else if (state_q == ST_WAIT_BND && take) begin
      lvl_q <= best_lvl;
    end
  end

  // Termination priority: bus error, then autovector, then a vector.
  always_comb begin
    if (bus_error_in_seen) begin
      vec_num = VEC_SPURIOUS;
    end else if (autovector_req_seen) begin
      vec_num = VEC_AUTO_BASE + {5'h00, lvl_q};
    end else begin
      vec_num = vec_sync;
    end
  end

  // Memory port: two stack pushes, then the table fetch.
  assign mem_req_o = (state_q == ST_PUSH_PC) || (state_q == ST_PUSH_SW) ||
                     (state_q == ST_FETCH);
  assign mem_we_o  = (state_q == ST_PUSH_PC) || (state_q == ST_PUSH_SW);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_addr_o  <= 32'h0000_0000;
      mem_wdata_o <= 32'h0000_0000;
    end else if (state_q == ST_WAIT_BND && take) begin
      mem_addr_o  <= ssp_q - STACK_STEP;
      mem_wdata_o <= pc_q;
    end else if (state_q == ST_PUSH_PC && mem_ack_i) begin
      // The stack pointer drops on this same edge, so step from the address.
      mem_addr_o  <= mem_addr_o - STACK_STEP;
      mem_wdata_o <= {16'h0000, swif.word};
    end else if (state_q == ST_ACK && state_d == ST_FETCH) begin
      mem_addr_o  <= vbr_q + {22'h000000, vec_num, 2'b00};
      mem_wdata_o <= 32'h0000_0000;
    end
  end

  // Acknowledge cycle outputs are held from registers for the whole cycle.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_cycle_o           <= 1'b0;
      function_code_lines_o <= FC_IDLE;
      ack_addr_o            <= 24'h000000;
    end else if (state_q == ST_PUSH_SW && mem_ack_i) begin
      ack_cycle_o           <= 1'b1;
      function_code_lines_o <= FC_CPU_SPACE;
      ack_addr_o            <= {ACK_ADDR_HIGH, lvl_q, ACK_ADDR_BIT0};
    end else if (state_q == ST_ACK && state_d == ST_FETCH) begin
      ack_cycle_o           <= 1'b0;
      function_code_lines_o <= FC_SUP_DATA;
      ack_addr_o            <= 24'h000000;
    end else if (state_q == ST_WAIT_BND && take) begin
      function_code_lines_o <= FC_SUP_DATA;
    end else if (state_q == ST_DONE) begin
      function_code_lines_o <= FC_IDLE;
    end
  end

  // The mask is loaded from the address bus one cycle into the cycle.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_load_q <= 1'b0;
    end else begin
      mask_load_q <= (state_q == ST_PUSH_SW) && mem_ack_i;
    end
  end
  assign swif.mask_load  = mask_load_q;
  assign swif.mask_value = ack_addr_o[3:1];
  assign swif.exc_entry  = mask_load_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spurious_o <= 1'b0;
    end else if (state_q == ST_ACK && state_d == ST_FETCH) begin
      spurious_o <= bus_error_in_seen;
    end else if (state_q == ST_DONE) begin
      spurious_o <= 1'b0;
    end
  end

  assign resume_o = (state_q == ST_DONE);

  // Programming model. Privileged registers need supervisor level.
  assign priv_sel = (reg_sel_i == REG_SSP) || (reg_sel_i == REG_VBR) ||
                    (reg_sel_i == REG_SFC) || (reg_sel_i == REG_DFC);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 16; i++) begin
        gpr_q[i] <= 32'h0000_0000;
      end
    end else if (reg_we_i && !reg_sel_i[4]) begin
      gpr_q[reg_sel_i[3:0]] <= reg_wdata_i;
    end
  end

  // Sequencer updates win over software for PC and SSP.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_q <= PC_RESET;
    end else if (state_q == ST_FETCH && mem_ack_i) begin
      pc_q <= mem_rdata_i;
    end else if (reg_we_i && reg_sel_i == REG_PC) begin
      pc_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ssp_q <= SSP_RESET;
    end else if (mem_we_o && mem_ack_i) begin
      ssp_q <= ssp_q - STACK_STEP;
    end else if (reg_we_i && reg_sel_i == REG_SSP && swif.supervisor) begin
      ssp_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vbr_q <= VBR_RESET;
      sfc_q <= 3'h0;
      dfc_q <= 3'h0;
    end else if (reg_we_i && swif.supervisor) begin
      if (reg_sel_i == REG_VBR) begin
        vbr_q <= reg_wdata_i;
      end
      if (reg_sel_i == REG_SFC) begin
        sfc_q <= reg_wdata_i[2:0];
      end
      if (reg_sel_i == REG_DFC) begin
        dfc_q <= reg_wdata_i[2:0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_re_i) begin
      if (!reg_sel_i[4]) begin
        reg_rdata_o <= gpr_q[reg_sel_i[3:0]];
      end else if (priv_sel && !swif.supervisor) begin
        reg_rdata_o <= 32'h0000_0000;
      end else begin
        case (reg_sel_i)
          REG_PC:  reg_rdata_o <= pc_q;
          REG_SSP: reg_rdata_o <= ssp_q;
          REG_VBR: reg_rdata_o <= vbr_q;
          REG_SFC: reg_rdata_o <= {29'h00000000, sfc_q};
          REG_DFC: reg_rdata_o <= {29'h00000000, dfc_q};
          default: reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_fault_q <= 1'b0;
    end else begin
      reg_fault_q <= (reg_we_i | reg_re_i) & priv_sel & ~swif.supervisor;
    end
  end

  assign priv_fault_o = reg_fault_q | swif.fault;
  assign pc_o         = pc_q;
endmodule // ias_sequencer

// ### rtl/ias_pkg.sv
package ias_pkg;

  // Acknowledge cycle encoding.
  localparam logic [2:0]  FC_CPU_SPACE   = 3'h7;
  localparam logic [2:0]  FC_SUP_DATA    = 3'h5;
  localparam logic [2:0]  FC_IDLE        = 3'h0;
  localparam logic [19:0] ACK_ADDR_HIGH  = 20'hFFFFF;
  localparam logic        ACK_ADDR_BIT0  = 1'h1;

  // Vector numbers.
  localparam logic [7:0]  VEC_SPURIOUS   = 8'h18;
  localparam logic [7:0]  VEC_AUTO_BASE  = 8'h18;
  localparam logic [2:0]  LVL_NMI        = 3'h7;
  localparam logic [2:0]  LVL_NONE       = 3'h0;

  // Status word layout and reset value.
  localparam int          SW_T_HI        = 15;
  localparam int          SW_T_LO        = 14;
  localparam int          SW_S           = 13;
  localparam int          SW_IP_HI       = 10;
  localparam int          SW_IP_LO       = 8;
  localparam int          SW_CC_HI       = 4;
  localparam logic [15:0] SW_RESET       = 16'h2700;
  localparam logic [15:0] SW_IMPL_MASK   = 16'hE71F;
  localparam logic [15:0] SW_CCR_MASK    = 16'h001F;

  // Programming model selectors and reset values.
  localparam logic [4:0]  REG_PC         = 5'h10;
  localparam logic [4:0]  REG_SSP        = 5'h11;
  localparam logic [4:0]  REG_VBR        = 5'h12;
  localparam logic [4:0]  REG_SFC        = 5'h13;
  localparam logic [4:0]  REG_DFC        = 5'h14;
  localparam logic [31:0] PC_RESET       = 32'h0000_0000;
  localparam logic [31:0] SSP_RESET      = 32'h0000_0000;
  localparam logic [31:0] VBR_RESET      = 32'h0000_0000;
  localparam logic [31:0] STACK_STEP     = 32'h0000_0004;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WAIT_BND = 3'b001,
    ST_PUSH_PC  = 3'b011,
    ST_PUSH_SW  = 3'b010,
    ST_ACK      = 3'b110,
    ST_FETCH    = 3'b111,
    ST_DONE     = 3'b101
  } ias_state_e;

endpackage

// ### rtl/ias_sw_if.sv
`timescale 1ns/1ps
interface ias_sw_if;
  logic        mask_load;
  logic [2:0]  mask_value;
  logic        exc_entry;
  logic [15:0] word;
  logic        supervisor;
  logic        fault;

  modport seq (
    output mask_load,
    output mask_value,
    output exc_entry,
    input  word,
    input  supervisor,
    input  fault
  );

  modport owner (
    input  mask_load,
    input  mask_value,
    input  exc_entry,
    output word,
    output supervisor,
    output fault
  );
endinterface

// ### rtl/ias_status_word.sv
`timescale 1ns/1ps
module ias_status_word (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  ias_sw_if.owner          sw,
  input  wire logic        sw_wr_i,
  input  wire logic        sw_wr_full_i,
  input  wire logic [15:0] sw_wdata_i,
  input  wire logic        sw_rd_i,
  input  wire logic        sw_rd_full_i,
  output logic      [15:0] sw_rdata_o
);
  import ias_pkg::*;

  logic [15:0] word_q;
  logic        fault_q;
  logic        user_full;

  // Whole-word access from user level is refused and reported.
  assign user_full = ~word_q[SW_S] &
                     ((sw_wr_i & sw_wr_full_i) | (sw_rd_i & sw_rd_full_i));

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_q <= SW_RESET;
    end else if (sw.mask_load || sw.exc_entry) begin
      // Exception entry takes priority over a software write.
      if (sw.mask_load) begin
        word_q[SW_IP_HI:SW_IP_LO] <= sw.mask_value;
      end
      if (sw.exc_entry) begin
        word_q[SW_S]              <= 1'b1;
        word_q[SW_T_HI:SW_T_LO]   <= 2'b00;
      end
    end else if (sw_wr_i && !user_full) begin
      if (sw_wr_full_i) begin
        word_q <= sw_wdata_i & SW_IMPL_MASK;
      end else begin
        word_q <= (word_q & ~SW_CCR_MASK) | (sw_wdata_i & SW_CCR_MASK);
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sw_rdata_o <= 16'h0000;
    end else if (sw_rd_i) begin
      if (sw_rd_full_i && word_q[SW_S]) begin
        sw_rdata_o <= word_q;
      end else begin
        sw_rdata_o <= word_q & SW_CCR_MASK;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= user_full;
    end
  end

  assign sw.word       = word_q;
  assign sw.supervisor = word_q[SW_S];
  assign sw.fault      = fault_q;
endmodule // ias_status_word

// ### verif/ias_sequencer_sva.sv
`timescale 1ns/1ps
module ias_sequencer_sva
  import ias_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic        boundary_i,
  input wire logic        exc_busy_i,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic        mem_ack_i,
  input wire logic        ack_cycle_o,
  input wire logic [2:0]  function_code_lines_o,
  input wire logic [23:0] ack_addr_o,
  input wire logic        resume_o,
  input wire logic        reg_we_i,
  input wire logic        reg_re_i,
  input wire logic        sw_wr_i,
  input wire logic        sw_rd_i,
  input wire logic        sw_rd_full_i,
  input wire logic [15:0] sw_rdata_o,
  input wire logic        priv_fault_o
);
  default clocking ck @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // The status push is the write that no further request follows.
  sequence s_last_push;
    mem_req_o && mem_we_o && mem_ack_i ##1 !mem_req_o;
  endsequence
  sequence s_two_ack;
    ack_cycle_o [*2];
  endsequence
  a_take_bound: assert property (
    $rose(mem_req_o) && mem_we_o |-> $past(boundary_i && !exc_busy_i))
    else $error("stacking began off a boundary");
  a_push_then_ack: assert property (s_last_push |-> ack_cycle_o)
    else $error("no acknowledge after stacking");
  a_ack_after_push: assert property (
    $rose(ack_cycle_o) |-> $past(mem_we_o && mem_ack_i))
    else $error("acknowledge without stacking");
  a_ack_fc: assert property (
    ack_cycle_o |-> function_code_lines_o == FC_CPU_SPACE)
    else $error("wrong function code in acknowledge");
  a_ack_addr: assert property (ack_cycle_o |->
    ack_addr_o[23:4] == ACK_ADDR_HIGH && ack_addr_o[0] == ACK_ADDR_BIT0)
    else $error("wrong acknowledge address");
  a_ack_level: assert property (s_two_ack |->
    $stable(ack_addr_o) && ack_addr_o[3:1] != LVL_NONE)
    else $error("acknowledge level unstable or zero");
  a_fetch_next: assert property ($fell(ack_cycle_o) |->
    mem_req_o && !mem_we_o && function_code_lines_o == FC_SUP_DATA)
    else $error("no vector fetch after acknowledge");
  a_mem_hold: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("memory request dropped early");
  a_resume_pulse: assert property (resume_o |=> !resume_o)
    else $error("resume longer than one cycle");
  a_fault_cause: assert property (priv_fault_o |->
    $past(reg_we_i || reg_re_i || sw_wr_i || sw_rd_i))
    else $error("fault without an access");
  a_user_view: assert property (
    priv_fault_o && $past(sw_rd_i && sw_rd_full_i) |->
    (sw_rdata_o & ~SW_CCR_MASK) == 16'h0000)
    else $error("user read saw system byte");
  a_zero_bits: assert property ($past(sw_rd_i) |->
    sw_rdata_o[12:11] == 2'h0 && sw_rdata_o[7:5] == 3'h0)
    else $error("unimplemented status bits set");
endmodule // ias_sequencer_sva

bind ias_sequencer ias_sequencer_sva u_sva (.*);

// ### verif/ias_partner.sv
`timescale 1ns/1ps
module ias_partner (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        mem_req_i,
  input  wire logic [31:0] mem_addr_i,
  output logic             mem_ack_o,
  output logic [31:0]      mem_rdata_o,
  input  wire logic        ack_cycle_i,
  input  wire logic [23:0] ack_addr_i,
  input  wire logic [2:0]  level_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [7:0]  vector_i,
  input  wire logic        slow_i,
  output logic [7:0]       ack_vector_o,
  output logic [1:0]       size_ack_lines_n_o,
  output logic             autovector_req_n_o,
  output logic             bus_error_in_n_o
);
  logic [1:0] wait_q;
  logic       hit;
  assign hit = ack_addr_i[3:1] == level_i;
  initial begin
    {mem_ack_o, mem_rdata_o, ack_vector_o, wait_q} = '0;
    {size_ack_lines_n_o, autovector_req_n_o, bus_error_in_n_o} = 4'hF;
  end
  // Released lines toggle so a stale value never passes for an answer.
  always @(negedge clock_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (size_ack_lines_n_o == 2'h3) begin
      ack_vector_o <= ~ack_vector_o;
    end
    if (!reset_n_i || !ack_cycle_i) begin
      {size_ack_lines_n_o, autovector_req_n_o, bus_error_in_n_o} <= 4'hF;
    end
    if (!reset_n_i || !(mem_req_i || ack_cycle_i) || mem_ack_o) begin
      wait_q <= slow_i ? 2'h3 : 2'h0;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (mem_req_i) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= ~mem_addr_i;
    end else if (mode_i == 2'h2 || !hit) begin
      bus_error_in_n_o <= 1'b0;
    end else if (mode_i == 2'h1) begin
      autovector_req_n_o <= 1'b0;
    end else if (size_ack_lines_n_o == 2'h3) begin
      size_ack_lines_n_o <= 2'h0;
      ack_vector_o <= vector_i;
    end
  end
endmodule // ias_partner

// ### verif/tb_ias_sequencer.sv
`timescale 1ns/1ps
module tb_ias_sequencer;
  import ias_pkg::*;
  logic        clock_i, reset_n_i, boundary_i, exc_busy_i, mem_req_o;
  logic        mem_we_o, mem_ack_i, ack_cycle_o, autovector_req_n_i;
  logic        bus_error_in_n_i, resume_o, spurious_o, reg_we_i;
  logic        reg_re_i, sw_wr_i, sw_wr_full_i, sw_rd_i, sw_rd_full_i;
  logic        priv_fault_o, p_slow, spur, flt;
  logic [7:1]  irq_n_i;
  logic [2:0]  function_code_lines_o, p_level, lv;
  logic [1:0]  size_ack_lines_n_i, p_mode;
  logic [7:0]  ack_vector_i, p_vector;
  logic [4:0]  reg_sel_i;
  logic [15:0] sw_wdata_i, sw_rdata_o, swv, rs;
  logic [23:0] ack_addr_o;
  logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, pc_o, reg_wdata_i;
  logic [31:0] reg_rdata_o, ssp, vbr, pcv, rd, dv;
  logic [31:0] wa [2];
  logic [31:0] wd [2];
  int          bad_count, total_checks, nwr, seed, i, k;

  ias_sequencer u_dut (.*);
  ias_partner u_far (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i), .ack_cycle_i(ack_cycle_o),
    .ack_addr_i(ack_addr_o), .level_i(p_level), .mode_i(p_mode),
    .vector_i(p_vector), .slow_i(p_slow), .ack_vector_o(ack_vector_i),
    .size_ack_lines_n_o(size_ack_lines_n_i),
    .autovector_req_n_o(autovector_req_n_i),
    .bus_error_in_n_o(bus_error_in_n_i));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (mem_req_o && mem_we_o && mem_ack_i) begin
      if (nwr < 2) begin
        wa[nwr] = mem_addr_o;
        wd[nwr] = mem_wdata_o;
      end
      nwr = nwr + 1;
    end
    if (spurious_o === 1'b1) begin
      spur = 1'b1;
    end
  end

  function automatic logic [7:0] exp_vec(logic [1:0] m, logic [2:0] l,
                                         logic [7:0] v);
    return m == 2'h0 ? v : m == 2'h1 ? VEC_AUTO_BASE + l : VEC_SPURIOUS;
  endfunction

  function automatic logic [31:0] exp_pc(logic [31:0] b, logic [7:0] v);
    return ~(b + {22'h0, v, 2'h0});
  endfunction

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clock_i);
  endtask

  // Kinds: 0 register write, 1 register read, 2 status write, 3 read.
  task automatic acc(int t, logic f, logic [4:0] s, logic [31:0] d);
    reg_sel_i = s;
    reg_wdata_i = d;
    sw_wdata_i = d[15:0];
    sw_wr_full_i = f;
    sw_rd_full_i = f;
    {reg_we_i, reg_re_i, sw_wr_i, sw_rd_i} = 4'h8 >> t;
    cyc(1);
    {reg_we_i, reg_re_i, sw_wr_i, sw_rd_i} = 4'h0;
    rd = reg_rdata_o;
    rs = sw_rdata_o;
    flt = priv_fault_o;
    cyc(1);
  endtask

  task automatic setsw(logic [15:0] d);
    acc(2, 1'b1, 5'h0, {16'h0, d});
    swv = d & SW_IMPL_MASK;
  endtask

  task automatic run_irq(logic [2:0] l, logic [1:0] m, logic hold);
    p_level = l;
    p_mode = m;
    p_vector = 8'($random(seed));
    p_slow = 1'($random(seed));
    nwr = 0;
    spur = 1'b0;
    exc_busy_i = hold;
    boundary_i = 1'b1;
    irq_n_i = ~(7'h01 << (l - 3'h1));
    if (hold) begin
      cyc(12);
      chk("held off", 0, nwr);
      exc_busy_i = 1'b0;
    end
    for (i = 0; i < 300 && resume_o !== 1'b1; i++) cyc(1);
    if (i == 300) begin
      bad_count++;
      complete_run;
    end
    irq_n_i = 7'h7F;
    boundary_i = 1'b0;
    dv = exp_pc(vbr, exp_vec(m, l, p_vector));
    chk("handler pc", dv, pc_o);
    chk("spurious", {31'h0, m == 2'h2}, {31'h0, spur});
    chk("push count", 2, nwr);
    chk("pc push addr", ssp - 32'h4, wa[0]);
    chk("pc push", pcv, wd[0]);
    chk("sw push addr", ssp - 32'h8, wa[1]);
    chk("sw push", {16'h0, swv}, wd[1]);
    pcv = dv;
    ssp = ssp - 32'h8;
    swv = {3'b001, 2'b00, l, swv[7:0]};
    acc(3, 1'b1, 5'h0, 32'h0);
    chk("status after", {16'h0, swv}, {16'h0, rs});
    cyc(4);
  endtask

  initial begin
    seed = 32'ha4de;
    {reset_n_i, boundary_i, exc_busy_i, reg_we_i, reg_re_i} = 5'h0;
    {sw_wr_i, sw_wr_full_i, sw_rd_i, sw_rd_full_i, p_slow} = 5'h0;
    {reg_sel_i, reg_wdata_i, sw_wdata_i} = '0;
    {p_level, p_mode, p_vector} = '0;
    {bad_count, total_checks, nwr} = '0;
    irq_n_i = 7'h7F;
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    reset_n_i = 1'b1;
    acc(3, 1'b1, 5'h0, 32'h0);
    chk("sw reset", {16'h0, SW_RESET}, {16'h0, rs});
    acc(1, 1'b0, REG_VBR, 32'h0);
    chk("vbr reset", VBR_RESET, rd);
    chk("pc reset", PC_RESET, pc_o);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      lv = 3'($random(seed));
      dv = $random(seed);
      acc(0, 1'b0, {1'b0, lv, k[0]}, dv);
      acc(1, 1'b0, {1'b0, lv, k[0]}, 32'h0);
      chk("general reg", dv, rd);
    end
    vbr = $random(seed) & 32'hFFFF_FC00;
    ssp = 32'h0000_8000;
    pcv = $random(seed) & 32'hFFFF_FFFE;
    acc(0, 1'b0, REG_VBR, vbr);
    acc(0, 1'b0, REG_SSP, ssp);
    acc(0, 1'b0, REG_PC, pcv);
    acc(1, 1'b0, REG_VBR, 32'h0);
    chk("vbr", vbr, rd);
    $display("test model done");
    for (k = 0; k < 6; k++) begin
      setsw(16'h2000 | 16'($random(seed) & 32'h1F));
      lv = 3'h1 + 3'(($random(seed) & 32'hFF) % 7);
      if (k == 5) lv = 3'h7;
      run_irq(lv, 2'(k % 3), k == 1);
    end
    $display("test service done");
    setsw(16'h2400);
    nwr = 0;
    lv = 3'h1 + 3'(($random(seed) & 32'hFF) % 4);
    irq_n_i = ~(7'h01 << (lv - 3'h1));
    boundary_i = 1'b1;
    cyc(20);
    chk("masked", 0, nwr);
    irq_n_i = 7'h7F;
    boundary_i = 1'b0;
    cyc(4);
    setsw(16'h2700);
    run_irq(3'h7, 2'h0, 1'b0);
    $display("test mask done");
    setsw(16'h001F);
    acc(3, 1'b1, 5'h0, 32'h0);
    chk("user status", 32'h001F, {16'h0, rs});
    chk("user fault", 1, {31'h0, flt});
    acc(0, 1'b0, REG_VBR, ~vbr);
    acc(1, 1'b0, REG_VBR, 32'h0);
    chk("user vbr", 0, rd);
    acc(2, 1'b0, 5'h0, 32'hFFF5);
    swv = {swv[15:8], 8'h15};
    acc(2, 1'b1, 5'h0, 32'h2700);
    run_irq(3'h2, 2'h1, 1'b0);
    acc(1, 1'b0, REG_VBR, 32'h0);
    chk("vbr kept", vbr, rd);
    $display("test user done");
    complete_run;
  end
endmodule // tb_ias_sequencer
